/* File: logic/frpc_pkg.sv */
// Purpose: Constants, types and table lookup for the flash reset block
// Assumes: pclk at 10 MHz; APB with 32-bit data
// Notes: Table bytes outside the known window read as blank
//
// How it works
// [R01] Reset pin low for 1 us or more gives a full reset
// [R02] After hardware reset: standby, all volatile bits at power-on value
// [R03] Reset pin low during program or erase aborts that operation at once
// [R04] Serial data output stays undriven while reset pin is low
// [R05] Host waits recovery time after reset: 20 us, or 12 ms after erase; a software reset during erase still counts only 20 us
// [R06] Power-up enters standby, not deep power-down, latch cleared
// [R07] Supply below inhibit threshold holds logic reset, ignores commands
// [R08] Host waits supply settle delay before read, write or erase commands; no delay is kept, cmd_ready rises on the first edge that sees supply_ok
// [R09] Host keeps chip select high through power-up and power-down
// [R10] Software reset needs 66h immediately followed by 99h
// [R11] Wrap read by C0h with 8, 16, 32 and 64 byte lengths, code 64h
// [R12] Volatile block lock bits set by 36h, protected after reset
// [R13] Feature flags report supported and unsupported features as listed
// [R14] Unused parameter table locations read FFh
// [R15] Table read accepted only in single, dual-all, quad-all lanes
// [R16] Host sends mode bits then dummy clocks before data returns
// [R17] Reset pin low: chip select and commands are ignored
`default_nettype none

package frpc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int RESET_PULSE_MIN_NS = 1000;
    localparam int RECOVERY_NS = 20000;
    localparam int RECOVERY_ERASE_MS = 12;
    // Least time rounds up, longest time rounds down
    localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVERY_CYC = RECOVERY_NS / CLK_NS;
    localparam int RECOVERY_ERASE_CYC = (RECOVERY_ERASE_MS * 1000000) / CLK_NS;
    localparam int CNT_W = 17;

    // ------------------------------------------------------------
    // Opcodes and lane codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_RESET_EN = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_WRAP = 8'hC0;
    localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
    localparam logic [7:0] OP_TABLE_READ = 8'h5A;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [1:0] LANE_SINGLE = 2'h0;
    localparam logic [1:0] LANE_DUAL_ALL = 2'h1;
    localparam logic [1:0] LANE_QUAD_ALL = 2'h2;
    localparam logic [2:0] WRAP_OFF = 3'h4;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LOCK = 8'h08;
    localparam logic [7:0] ADDR_TBL_ADDR = 8'h0C;
    localparam logic [7:0] ADDR_TBL_DATA = 8'h10;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [7:0] BLANK = 8'hFF;

    typedef enum logic [4:0] {
        ST_POWER = 5'h01,
        ST_STANDBY = 5'h02,
        ST_PIN = 5'h04,
        ST_RESET = 5'h08,
        ST_RECOVER = 5'h10
    } frpc_state_e;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [7:0] arg;
    } frpc_cmd_s;

    // Parameter table tail; everything else reads blank
    function automatic logic [7:0] frpc_table(input logic [7:0] a);
        case (a)
            8'h60: frpc_table = 8'h00;
            8'h61: frpc_table = 8'h20;
            8'h62: frpc_table = 8'h50;
            8'h63: frpc_table = 8'h16;
            8'h64: frpc_table = 8'h9D; // [R13]
            8'h65: frpc_table = 8'hF9; // [R13]
            8'h66: frpc_table = OP_WRAP; // [R11]
            8'h67: frpc_table = 8'h64; // [R11]
            8'h68: frpc_table = 8'hD9; // [R12]
            8'h69: frpc_table = 8'hC8; // [R13]
            default: frpc_table = BLANK; // [R14]
        endcase
    endfunction
endpackage

`default_nettype wire

/* File: logic/frpc_top.sv */
// Purpose: Reset, power-on and software reset control of a serial flash
// Assumes: all inputs synchronous to pclk; APB slave with one wait state
// Notes: reset pin and supply flag are levels sampled each cycle
//
// The implementer's own choices: the APB register port and the register addresses.
`default_nettype none

module frpc_top #(
    parameter int NBLK = 16,
    parameter int ERASE_RECOVERY_CYC = frpc_pkg::RECOVERY_ERASE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    input wire logic cs_n,
    input wire frpc_pkg::frpc_cmd_s cmd,
    input wire logic supply_ok,
    input wire logic core_busy,
    input wire logic core_erasing,
    output logic core_abort,
    output logic so_oe,
    output logic write_enable_latch,
    output logic write_in_progress,
    output logic [NBLK-1:0] block_lock,
    output logic table_read_go,
    output logic [2:0] wrap_len,
    output logic cmd_ready
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    frpc_pkg::frpc_state_e state;
    frpc_pkg::frpc_state_e next_state;
    logic [frpc_pkg::CNT_W-1:0] cnt;
    logic [frpc_pkg::CNT_W-1:0] next_cnt;
    logic rst_armed;
    logic erase_cut;
    logic sw_reset;
    logic [1:0] lane_mode;
    logic [7:0] tbl_addr;
    logic table_reject;
    logic cmd_take;
    logic vclr;
    logic apb_done;

    localparam logic [frpc_pkg::CNT_W-1:0] PULSE_MIN =
        frpc_pkg::CNT_W'(frpc_pkg::RESET_PULSE_MIN_CYC);
    localparam logic [frpc_pkg::CNT_W-1:0] REC_CYC =
        frpc_pkg::CNT_W'(frpc_pkg::RECOVERY_CYC);
    localparam logic [frpc_pkg::CNT_W-1:0] REC_ERASE =
        frpc_pkg::CNT_W'(ERASE_RECOVERY_CYC);

    // Commands are decoded only in standby with the pin high and supply valid
    assign cmd_take = cmd.valid && !cs_n && reset_pin_n && supply_ok
        && (state == frpc_pkg::ST_STANDBY); // [R17] [R07]

    // Software reset fires only on 99h right after 66h
    assign sw_reset = cmd_take && rst_armed && (cmd.opcode == frpc_pkg::OP_RESET); // [R10]

    // Volatile bits go to power-on value in these conditions
    assign vclr = (state == frpc_pkg::ST_POWER) || (state == frpc_pkg::ST_RESET)
        || sw_reset; // [R02] [R06]

    assign apb_done = psel && penable && pready;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Pin and supply take priority over everything in flight
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            frpc_pkg::ST_POWER: begin
                if (supply_ok) begin
                    next_state = frpc_pkg::ST_STANDBY; // [R06]
                end
            end
            frpc_pkg::ST_STANDBY: begin
                if (!reset_pin_n) begin
                    next_state = frpc_pkg::ST_PIN;
                    next_cnt = frpc_pkg::CNT_W'(1);
                end else if (sw_reset) begin
                    next_state = frpc_pkg::ST_RECOVER;
                    next_cnt = REC_CYC;
                end
            end
            frpc_pkg::ST_PIN: begin
                // Short pulses fall back to standby without a full reset
                if (reset_pin_n) begin
                    next_state = frpc_pkg::ST_STANDBY;
                end else if (cnt >= PULSE_MIN - frpc_pkg::CNT_W'(1)) begin
                    next_state = frpc_pkg::ST_RESET; // [R01]
                end else begin
                    next_cnt = cnt + frpc_pkg::CNT_W'(1);
                end
            end
            frpc_pkg::ST_RESET: begin
                if (reset_pin_n) begin
                    next_state = frpc_pkg::ST_RECOVER;
                    next_cnt = erase_cut ? REC_ERASE : REC_CYC; // [R05]
                end
            end
            frpc_pkg::ST_RECOVER: begin
                if (!reset_pin_n) begin
                    next_state = frpc_pkg::ST_PIN;
                    next_cnt = frpc_pkg::CNT_W'(1);
                end else if (cnt <= frpc_pkg::CNT_W'(1)) begin
                    next_state = frpc_pkg::ST_STANDBY;
                end else begin
                    next_cnt = cnt - frpc_pkg::CNT_W'(1);
                end
            end
        endcase
        if (!supply_ok) begin
            next_state = frpc_pkg::ST_POWER; // [R07]
            next_cnt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= frpc_pkg::ST_POWER;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // Abort of program or erase
    // ------------------------------------------------------------
    // Abort as soon as the pin drops, not after the minimum pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_abort <= 1'b0;
            erase_cut <= 1'b0;
        end else begin
            core_abort <= core_busy && (!reset_pin_n || !supply_ok || sw_reset); // [R03]
            if (state == frpc_pkg::ST_STANDBY && !reset_pin_n) begin
                erase_cut <= core_busy && core_erasing; // [R05]
            end
        end
    end

    // ------------------------------------------------------------
    // Pin-facing outputs
    // ------------------------------------------------------------
    // Output driver only while selected and fully out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_oe <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            so_oe <= reset_pin_n && !cs_n && (next_state == frpc_pkg::ST_STANDBY); // [R04]
            cmd_ready <= reset_pin_n && (next_state == frpc_pkg::ST_STANDBY); // [R17]
        end
    end

    // ------------------------------------------------------------
    // Volatile flags
    // ------------------------------------------------------------
    // Busy mirrors the core, but is forced idle by any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_in_progress <= 1'b0;
        end else begin
            write_in_progress <= core_busy && !vclr && reset_pin_n; // [R02]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_enable_latch <= 1'b0;
        end else if (vclr) begin
            write_enable_latch <= 1'b0; // [R02] [R06]
        end else if (cmd_take && cmd.opcode == frpc_pkg::OP_WREN) begin
            write_enable_latch <= 1'b1;
        end else if (cmd_take && cmd.opcode == frpc_pkg::OP_WRDI) begin
            write_enable_latch <= 1'b0;
        end
    end

    // Any other command in between disarms the reset enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_armed <= 1'b0;
        end else if (vclr) begin
            rst_armed <= 1'b0;
        end else if (cmd_take) begin
            rst_armed <= (cmd.opcode == frpc_pkg::OP_RESET_EN); // [R10]
        end
    end

    // Locks default protected; software may open blocks via the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_lock <= '1;
        end else if (vclr) begin
            block_lock <= '1; // [R12]
        end else if (cmd_take && cmd.opcode == frpc_pkg::OP_BLOCK_LOCK) begin
            block_lock[cmd.arg[$clog2(NBLK)-1:0]] <= 1'b1; // [R12]
        end else if (apb_done && pwrite && paddr == frpc_pkg::ADDR_LOCK) begin
            block_lock <= pwdata[NBLK-1:0];
        end
    end

    // Wrap argument bits 2:0 of 0..3 pick 8 << arg bytes; bit 2 set turns wrap off, higher bits ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_len <= frpc_pkg::WRAP_OFF;
        end else if (vclr) begin
            wrap_len <= frpc_pkg::WRAP_OFF;
        end else if (cmd_take && cmd.opcode == frpc_pkg::OP_WRAP) begin
            wrap_len <= cmd.arg[2] ? frpc_pkg::WRAP_OFF : cmd.arg[2:0]; // [R11]
        end
    end

    // Table read only in the three all-lane or single configurations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_read_go <= 1'b0;
            table_reject <= 1'b0;
        end else begin
            table_read_go <= cmd_take && cmd.opcode == frpc_pkg::OP_TABLE_READ
                && lane_mode != 2'h3; // [R15]
            if (cmd_take && cmd.opcode == frpc_pkg::OP_TABLE_READ && lane_mode == 2'h3) begin
                table_reject <= 1'b1; // [R15]
            end else if (apb_done && !pwrite && paddr == frpc_pkg::ADDR_STATUS) begin
                table_reject <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state so that ready and read data both come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && penable && !pready) begin
                case (paddr)
                    frpc_pkg::ADDR_CTRL: prdata <= {30'h0, lane_mode};
                    frpc_pkg::ADDR_STATUS: prdata <= {16'h0, 3'h0, state,
                        wrap_len, table_reject, rst_armed, erase_cut,
                        write_in_progress, write_enable_latch};
                    frpc_pkg::ADDR_LOCK: prdata <= 32'(block_lock);
                    frpc_pkg::ADDR_TBL_ADDR: prdata <= {24'h0, tbl_addr};
                    frpc_pkg::ADDR_TBL_DATA: prdata <= {24'h0, frpc_pkg::frpc_table(tbl_addr)}; // [R14]
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_mode <= frpc_pkg::CTRL_RESET;
            tbl_addr <= '0;
        end else if (apb_done && pwrite) begin
            if (paddr == frpc_pkg::ADDR_CTRL) begin
                lane_mode <= pwdata[1:0];
            end
            if (paddr == frpc_pkg::ADDR_TBL_ADDR) begin
                tbl_addr <= pwdata[7:0];
            end
        end
    end
endmodule

`default_nettype wire

/* File: test/frpc_host.sv */
// Purpose: Host controller model that drives the reset pin and commands
// Assumes: one command per cycle, chip select low only for that cycle
// Notes: released command lines carry inverted data, never the last value
`default_nettype none

module frpc_host (
    input wire logic pclk,
    input wire logic cmd_ready,
    output logic reset_pin_n,
    output logic cs_n,
    output frpc_pkg::frpc_cmd_s cmd
);
    timeunit 1ns;
    timeprecision 1ns;

    // Deselected and quiet until a test asks for traffic
    initial begin
        reset_pin_n = 1'b1;
        cs_n = 1'b1;
        cmd = '0;
    end

    // One command; cmd_ready is waited for first, for at most 400 cycles
    task automatic send(input logic [7:0] op, input logic [7:0] arg);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        cs_n <= 1'b0;
        cmd <= '{1'b1, op, arg};
        @(posedge pclk);
        cs_n <= 1'b1;
        cmd <= '{1'b0, ~op, ~arg};
    endtask

    // Pin low for n cycles; ten or more make a full reset
    task automatic pin_reset(input int n);
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge pclk);
        reset_pin_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: test/frpc_asserts.sv */
// Purpose: Port-level checks of reset, power hold and register access
// Assumes: one clock domain, asynchronous active-low reset
// Notes: helper counters track pin low time and the reset-enable arm
`default_nettype none

module frpc_checker #(
    parameter int NBLK = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic reset_pin_n,
    input wire logic cs_n,
    input wire frpc_pkg::frpc_cmd_s cmd,
    input wire logic supply_ok,
    input wire logic core_busy,
    input wire logic core_abort,
    input wire logic so_oe,
    input wire logic write_enable_latch,
    input wire logic [NBLK-1:0] block_lock,
    input wire logic [2:0] wrap_len,
    input wire logic cmd_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [3:0] low_cnt;
    logic armed;
    logic taken;
    assign taken = cmd.valid && !cs_n && reset_pin_n && supply_ok && cmd_ready;

    // Saturating count of pin-low cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt <= 4'h0;
        else if (reset_pin_n) low_cnt <= 4'h0;
        else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
    end

    // Armed only by a taken enable; any other taken command disarms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) armed <= 1'b0;
        else if (!reset_pin_n || !supply_ok) armed <= 1'b0;
        else if (taken) armed <= (cmd.opcode == frpc_pkg::OP_RESET_EN);
    end

    pin_hiz_a: assert property (!reset_pin_n |=> !so_oe)
        else $error("data output enabled while pin reset");
    pin_abort_a: assert property (!reset_pin_n && core_busy |=> core_abort)
        else $error("operation not aborted by pin reset");
    pin_deaf_a: assert property (!reset_pin_n |=> !cmd_ready)
        else $error("commands accepted during pin reset");
    full_reset_a: assert property (low_cnt == 4'hC |-> !write_enable_latch && &block_lock)
        else $error("volatile state kept after long pin reset");
    soft_reset_a: assert property (taken && armed && cmd.opcode == frpc_pkg::OP_RESET
        |=> !write_enable_latch && &block_lock && !cmd_ready)
        else $error("software reset pair had no effect");
    power_hold_a: assert property (!supply_ok |=> !cmd_ready && !so_oe)
        else $error("logic active below inhibit level");
    wrap_code_a: assert property (wrap_len <= 3'h4)
        else $error("wrap length code out of range");
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    apb_error_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
endmodule

bind frpc_top frpc_checker #(.NBLK(NBLK)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .reset_pin_n(reset_pin_n), .cs_n(cs_n), .cmd(cmd), .supply_ok(supply_ok),
    .core_busy(core_busy), .core_abort(core_abort), .so_oe(so_oe),
    .write_enable_latch(write_enable_latch), .block_lock(block_lock),
    .wrap_len(wrap_len), .cmd_ready(cmd_ready));

`default_nettype wire

/* File: test/frpc_top_bench.sv */
// Purpose: Self-checking bench for the flash reset control block
// Assumes: erase recovery shortened to 300 cycles
// Notes: checks sample at the falling edge, inputs move on the rising edge
`default_nettype none

module frpc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_ok;
    logic core_busy, core_erasing, core_abort, so_oe, write_enable_latch;
    logic write_in_progress, table_read_go, cmd_ready, reset_pin_n, cs_n, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] block_lock;
    logic [2:0] wrap_len;
    frpc_pkg::frpc_cmd_s cmd;
    int fail_count = 0, cmp_count = 0, go_n = 0, abort_n = 0, cyc = 0, n0;
    logic [7:0] tbl [16] = '{8'h00, 8'h20, 8'h50, 8'h16, 8'h9D, 8'hF9, 8'hC0, 8'h64,
        8'hD9, 8'hC8, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    frpc_top #(.NBLK(16), .ERASE_RECOVERY_CYC(300)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .cs_n(cs_n), .cmd(cmd), .supply_ok(supply_ok), .core_busy(core_busy),
        .core_erasing(core_erasing), .core_abort(core_abort), .so_oe(so_oe),
        .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
        .block_lock(block_lock), .table_read_go(table_read_go), .wrap_len(wrap_len),
        .cmd_ready(cmd_ready));
    frpc_host host (.pclk(pclk), .cmd_ready(cmd_ready), .reset_pin_n(reset_pin_n),
        .cs_n(cs_n), .cmd(cmd));

    // ------------------------------------------------------------
    // Clock, pulse counters and hang guard
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Pulses are counted so a check need not hit their one cycle
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (table_read_go === 1'b1) go_n <= go_n + 1;
        if (core_abort === 1'b1) abort_n <= abort_n + 1;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Setup then access, held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rq, output logic re);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic re;
        apb(1'b1, a, d, rq, re);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] rq);
        logic re;
        apb(1'b0, a, 32'h0, rq, re);
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, supply_ok, core_busy, core_erasing} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        gap(5);
        chk("ready_low_supply", 32'h0, cmd_ready);
        @(posedge pclk);
        supply_ok <= 1'b1;
        gap(3);
        chk("ready_powered", 32'h1, cmd_ready);
        rd(frpc_pkg::ADDR_STATUS, q);
        chk("state_pwr", frpc_pkg::ST_STANDBY, q[12:8]);
        chk("wel_wip_pwr", 32'h0, q[1:0]);
        rd(frpc_pkg::ADDR_LOCK, q);
        chk("lock_pwr", 32'h0000FFFF, q);
        apb(1'b0, 8'h14, 32'h0, q, e);
        chk("unmapped_err", 32'h1, e);
        chk("unmapped_data", 32'h0, q);
        // Table tail, then blank fill of the unused words
        for (int i = 0; i < 16; i++) begin
            wr(frpc_pkg::ADDR_TBL_ADDR, 32'h60 + i);
            rd(frpc_pkg::ADDR_TBL_DATA, q);
            chk("table_byte", tbl[i], q);
        end
        // A command between enable and reset disarms the pair
        host.send(frpc_pkg::OP_WREN, 8'h00);
        wr(frpc_pkg::ADDR_LOCK, 32'h0);
        host.send(frpc_pkg::OP_RESET_EN, 8'h00);
        host.send(frpc_pkg::OP_WRAP, 8'h00);
        host.send(frpc_pkg::OP_RESET, 8'h00);
        rd(frpc_pkg::ADDR_LOCK, q);
        chk("lock_disarmed", 32'h0, q);
        host.send(frpc_pkg::OP_RESET_EN, 8'h00);
        host.send(frpc_pkg::OP_RESET, 8'h00);
        gap(1);
        chk("ready_sw", 32'h0, cmd_ready);
        chk("wel_sw", 32'h0, write_enable_latch);
        chk("lock_sw", 32'h0000FFFF, block_lock);
        for (int a = 0; a < 4; a++) begin
            host.send(frpc_pkg::OP_WRAP, 8'(a));
            gap(1);
            chk("wrap_len", a, wrap_len);
        end
        // Lane code 3 must refuse the table read
        for (int l = 0; l < 4; l++) begin
            wr(frpc_pkg::ADDR_CTRL, l);
            n0 = go_n;
            host.send(frpc_pkg::OP_TABLE_READ, 8'h00);
            gap(2);
            chk("table_go", l < 3, go_n - n0);
            rd(frpc_pkg::ADDR_STATUS, q);
            chk("table_reject", l == 3, q[4]);
        end
        wr(frpc_pkg::ADDR_CTRL, 32'h0);
        // Long pin reset in mid-erase
        host.send(frpc_pkg::OP_WREN, 8'h00);
        @(posedge pclk);
        core_busy <= 1'b1;
        core_erasing <= 1'b1;
        host.pin_reset(12);
        gap(1);
        chk("abort_seen", 32'h1, abort_n > 0);
        chk("wel_hw", 32'h0, write_enable_latch);
        chk("wip_hw", 32'h0, write_in_progress);
        chk("so_oe_hw", 32'h0, so_oe);
        chk("lock_hw", 32'h0000FFFF, block_lock);
        @(posedge pclk);
        core_busy <= 1'b0;
        core_erasing <= 1'b0;
        gap(240);
        chk("erase_recovery", 32'h0, cmd_ready);
        gap(100);
        chk("recovered", 32'h1, cmd_ready);
        give_verdict();
    end
endmodule

`default_nettype wire
